// File: cbuv_defs.svh
// Purpose: shared constants of the balance uv sequencer
// Assumes: apb byte addresses, 14 cells
// Notes: offsets, field positions, codes and counts
`ifndef CBUV_DEFS_SVH
`define CBUV_DEFS_SVH
`define CBUV_OFS_CTRL     8'h00
`define CBUV_OFS_THR      8'h04
`define CBUV_OFS_UVST     8'h08
`define CBUV_OFS_SWEN     8'h0c
`define CBUV_OFS_CELLCFG  8'h10
`define CBUV_OFS_DLY      8'h14
`define CBUV_OFS_SCAN     8'h18
`define CBUV_OFS_STAT     8'h1c
`define CBUV_LAST_CELL    4'hd
`define CBUV_MODE_OFF     3'h0
`define CBUV_MODE_DIS     3'h2
`define CBUV_MEAS_CHECK   2'h3
`define CBUV_FC_UNUSED    3'h7
`define CBUV_FC_SUB       3'h0
`define CBUV_SETTLE       5'h10
`define CBUV_MCNT_MAX     5'h1f
`define CBUV_OVS_16X      3'h4
`define CBUV_SCAN_PYRAMID 1'h1
`define CBUV_CTRL_MEAS    5:4
`define CBUV_CTRL_INIT    6
`define CBUV_CTRL_HOLD    9:8
`define CBUV_THR_MIN      15
`define CBUV_DLY_APPLY    4
`define CBUV_DLY_FC       10:8
`define CBUV_CFG_POL      29:16
`define CBUV_STAT_REJ     2
`endif

// File: cbuv_pkg.sv
// Purpose: types of the balance uv sequencer
// Assumes: constants live in cbuv_defs.svh
// Notes: one packed state struct per clocked module
package cbuv_pkg;
  typedef enum logic [1:0] {CBUV_IDLE, CBUV_RUN, CBUV_ACQ, CBUV_HALT} cbuv_state_t;
  typedef struct packed {
    cbuv_state_t state;
    logic [2:0]  mode;
    logic [1:0]  meas_en;
    logic        finit;
    logic [1:0]  hold;
    logic [13:0] thr;
    logic        thr_min;
    logic [13:0] flags;
    logic [13:0] swen;
    logic [13:0] meas_on;
    logic [13:0] pol;
    logic [2:0]  cal_int;
    logic        apply_cal;
    logic [2:0]  fc;
    logic [15:0] scan;
    logic        cal_fault;
    logic        rej;
    logic        active;
    logic [5:0]  cyc;
    logic [4:0]  mcnt;
    logic        cal_op;
    logic        s1_valid;
    logic [3:0]  s1_cell;
    logic [13:0] s1_data;
    logic        apb_rd;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [13:0] sw;
    logic        adc_start;
    logic        adc_cal;
    logic [2:0]  adc_ovs;
    logic        adc_pyr;
    logic [15:0] adc_scan;
  } cbuv_seq_t;
  typedef struct packed {
    logic [13:0][16:0] mem;
    logic [16:0]       rdata;
  } cbuv_mem_t;
endpackage

// File: cbuv_acc_mem.sv
// Purpose: per-cell filter accumulators, 14 x 17 bits
// Assumes: one read and one write port
// Notes: read data registered, one cycle latency
`timescale 1ns/10ps
`include "cbuv_defs.svh"
module cbuv_acc_mem import cbuv_pkg::*; (
  input  logic        pclk,
  input  logic        presetn,
  input  logic [3:0]  rd_addr,
  input  logic        wr_en,
  input  logic [3:0]  wr_addr,
  input  logic [16:0] wr_data,
  output logic [16:0] rd_data
);
  cbuv_mem_t st_reg, st_next;

  // out-of-range addresses read zero, writes dropped
  always_comb begin
    st_next = st_reg;
    st_next.rdata = (rd_addr <= `CBUV_LAST_CELL) ? st_reg.mem[rd_addr] : 17'h00000;
    if (wr_en && wr_addr <= `CBUV_LAST_CELL) begin
      st_next.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rdata;
endmodule // cbuv_acc_mem

// File: cbuv_iir.sv
// Purpose: one step of the per-cell filter
// Assumes: accumulator holds result with 3 fraction bits
// Notes: purely combinational, weight (code+1)/8, code 7 taken as code 0
`timescale 1ns/10ps
`include "cbuv_defs.svh"
module cbuv_iir (
  input  logic [16:0] acc_in,
  input  logic [13:0] sample,
  input  logic [2:0]  coef,
  input  logic        init,
  output logic [16:0] acc_out
);
  logic [2:0]         ceff;
  logic signed [18:0] diff;
  logic signed [23:0] prod;
  logic signed [23:0] sum;

  // unused filter still debounces at the lightest weight
  assign ceff = (coef == `CBUV_FC_UNUSED) ? `CBUV_FC_SUB : coef;
  assign diff = $signed({2'b00, sample, 3'b000}) - $signed({2'b00, acc_in});
  assign prod = diff * $signed({2'b00, ceff} + 5'h01);
  assign sum  = $signed({7'h00, acc_in}) + (prod >>> 3);
  // init loads the raw sample, dropping history
  assign acc_out = init ? {sample, 3'b000} : sum[16:0];
endmodule // cbuv_iir

// File: cbuv_seq.sv
// Purpose: balancing measurement, calibration and uv stop sequencer
// Assumes: apb master, adc and expiry timer are outside
// Notes: one acquisition per even/odd pair when measuring
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "cbuv_defs.svh"
// Behaviour
// - unsupported cell ends with its flag set
// - result below threshold sets flag, stops cell
// - flags cleared only by control write
// - threshold stop only with measure enable 11
// - all cells done opens every switch
// - threshold is 14 bits, 305 uV lsb
// - threshold write loads value or lowest cell
// - threshold read shows value and option bit
// - measure enable 0x skips all measurements
// - 1x measures, 11 also checks in auto
// - measure enable honoured in discharge/auto only
// - forced 16x oversampling and pyramid order
// - scan writes while active rejected with alert
// - unused coefficient replaced by one eighth
// - init select 0 keeps accumulators
// - init select 1 loads, checks from 17th
// - one acquisition after each even/odd pair
// - calibration interval needs measure enable 1x
// - interval zero means no calibrations
// - first and every nth acquisition calibrates
// - calibration range alert halts balancing
// - after fault skip all but expiry timer
// - checks need switch, measure on, unipolar
module cbuv_seq import cbuv_pkg::*; (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        pair_done,
  input  logic        timer_expired,
  input  logic        adc_done,
  input  logic        adc_result_valid,
  input  logic [3:0]  adc_result_cell,
  input  logic [13:0] adc_result_data,
  input  logic        calibration_range_alert,
  input  logic [3:0]  lowest_cell_index,
  output logic [13:0] switch_on,
  output logic        adc_start,
  output logic        adc_cal,
  output logic [2:0]  adc_oversample,
  output logic        adc_pyramid,
  output logic [15:0] adc_scan_cfg,
  output logic        balance_active,
  output logic        balance_cal_fault_alert,
  output logic        write_rejected_alert,
  output logic [13:0] cell_uv_done_flags
);
  cbuv_seq_t   st_reg, st_next;
  logic        apb_acc, apb_go, wr_go, ctrl_wr, scan_wr, adc_take;
  logic        is_auto, is_dis, meas_ok, chk_ok, cal_ok, chk_now;
  logic        init_now, hit, all_done, addr_ok, acq_done;
  logic [13:0] unsup, hit_vec;
  logic [13:0] res, mem_res;
  logic [16:0] mem_rd, new_acc;
  logic [5:0]  cal_n, cyc_inc;
  logic [31:0] rd_mux;

  // apb handshake: one grant cycle for the memory port, then ready
  assign apb_acc = psel && penable && !st_reg.pready;
  assign apb_go  = apb_acc && st_reg.apb_rd;
  assign wr_go   = apb_go && pwrite;
  assign ctrl_wr = wr_go && paddr == `CBUV_OFS_CTRL;
  assign scan_wr = wr_go && (paddr == `CBUV_OFS_SCAN || paddr == `CBUV_OFS_CELLCFG);

  // mode decode; measure enable only counts in discharge/auto
  assign is_dis  = st_reg.mode == `CBUV_MODE_DIS;
  assign is_auto = st_reg.mode[2];
  assign meas_ok = (is_dis || is_auto) && st_reg.meas_en[1];
  assign chk_ok  = is_auto && st_reg.meas_en == `CBUV_MEAS_CHECK;
  assign cal_ok  = meas_ok && st_reg.cal_int != 3'h0;

  // cells that cannot be checked end right away
  assign unsup = st_reg.swen & (~st_reg.meas_on | st_reg.pol);

  // result pipeline: stage 0 reads accumulator, stage 1 writes it
  assign adc_take = adc_result_valid && st_reg.state == CBUV_ACQ && !st_reg.cal_op;
  assign acq_done = st_reg.state == CBUV_ACQ && adc_done;
  assign init_now = st_reg.finit && st_reg.mcnt == 5'h00;
  assign chk_now  = chk_ok && (!st_reg.finit || st_reg.mcnt >= `CBUV_SETTLE);
  assign res      = new_acc[16:3];
  assign mem_res  = mem_rd[16:3];
  assign hit      = st_reg.s1_valid && chk_now && res < st_reg.thr;
  assign hit_vec  = hit ? (14'h0001 << st_reg.s1_cell) & st_reg.swen : 14'h0000;
  assign all_done = chk_ok && st_reg.swen != 14'h0000 &&
                    (st_reg.swen & ~st_reg.flags) == 14'h0000;

  cbuv_acc_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .rd_addr (adc_take ? adc_result_cell : lowest_cell_index),
    .wr_en   (st_reg.s1_valid),
    .wr_addr (st_reg.s1_cell),
    .wr_data (new_acc),
    .rd_data (mem_rd)
  );

  cbuv_iir u_iir (
    .acc_in  (mem_rd),
    .sample  (st_reg.s1_data),
    .coef    (st_reg.fc),
    .init    (init_now),
    .acc_out (new_acc)
  );

  // calibration period in acquisitions
  always_comb begin
    case (st_reg.cal_int)
      3'h1:    cal_n = 6'h02;
      3'h2:    cal_n = 6'h04;
      3'h3:    cal_n = 6'h08;
      3'h4:    cal_n = 6'h0c;
      3'h5:    cal_n = 6'h10;
      3'h6:    cal_n = 6'h18;
      3'h7:    cal_n = 6'h20;
      default: cal_n = 6'h01;
    endcase
  end
  assign cyc_inc = st_reg.cyc + 6'h01;

  // register read mux
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      `CBUV_OFS_CTRL:    rd_mux = {22'h0, st_reg.hold, 1'b0, st_reg.finit,
                                   st_reg.meas_en, 1'b0, st_reg.mode};
      `CBUV_OFS_THR:     rd_mux = {16'h0, st_reg.thr_min, 1'b0, st_reg.thr};
      `CBUV_OFS_UVST:    rd_mux = {18'h0, st_reg.flags};
      `CBUV_OFS_SWEN:    rd_mux = {18'h0, st_reg.swen};
      `CBUV_OFS_CELLCFG: rd_mux = {2'h0, st_reg.pol, 2'h0, st_reg.meas_on};
      `CBUV_OFS_DLY:     rd_mux = {21'h0, st_reg.fc, 3'h0, st_reg.apply_cal,
                                   1'b0, st_reg.cal_int};
      `CBUV_OFS_SCAN:    rd_mux = {16'h0, st_reg.scan};
      `CBUV_OFS_STAT:    rd_mux = {28'h0, all_done, st_reg.rej,
                                   st_reg.cal_fault, st_reg.active};
      default: begin
        rd_mux  = 32'h0;
        addr_ok = 1'b0;
      end
    endcase
  end

  // whole next state: sequencer, apb slave, flags, outputs
  always_comb begin
    st_next = st_reg;
    st_next.adc_start = 1'b0;
    st_next.pready = 1'b0;
    st_next.s1_valid = adc_take;
    st_next.s1_cell = adc_result_cell;
    st_next.s1_data = adc_result_data;

    // sequencer
    case (st_reg.state)
      CBUV_IDLE: begin
        st_next.cal_op = 1'b0;
      end
      CBUV_RUN: begin
        // one acquisition per even/odd pair
        if (pair_done && meas_ok) begin
          st_next.state = CBUV_ACQ;
          st_next.adc_start = 1'b1;
          st_next.adc_cal = cal_ok && st_reg.cyc == 6'h00;
          st_next.cal_op = cal_ok && st_reg.cyc == 6'h00;
          st_next.adc_ovs = `CBUV_OVS_16X;
          st_next.adc_pyr = `CBUV_SCAN_PYRAMID;
          st_next.adc_scan = st_reg.scan;
        end
      end
      CBUV_ACQ: begin
        if (adc_done) begin
          if (!st_reg.cal_op && st_reg.mcnt != `CBUV_MCNT_MAX) begin
            st_next.mcnt = st_reg.mcnt + 5'h01;
          end
          if (cal_ok) begin
            st_next.cyc = (cyc_inc >= cal_n) ? 6'h00 : cyc_inc;
          end
          // out-of-range calibration spoils results: stop switching
          if (st_reg.apply_cal && calibration_range_alert) begin
            st_next.cal_fault = 1'b1;
            st_next.state = CBUV_HALT;
          end else begin
            st_next.state = CBUV_RUN;
          end
        end
      end
      CBUV_HALT: begin
        st_next.cal_op = 1'b0;
      end
      default: begin
        st_next.state = CBUV_IDLE;
      end
    endcase

    // expiry ends every operation, halted ones too
    if (timer_expired && st_reg.active) begin
      st_next.active = 1'b0;
      st_next.state = CBUV_IDLE;
    end

    // flags: threshold hits survive the launch clear, unsupported-cell sets do not
    st_next.flags = st_reg.flags | hit_vec;
    if (chk_ok && (st_reg.state == CBUV_RUN || st_reg.state == CBUV_ACQ)) begin
      st_next.flags = st_next.flags | unsup;
    end

    // apb: grant memory port only while no result needs it
    if (apb_acc && !st_reg.apb_rd && !adc_take) begin
      st_next.apb_rd = 1'b1;
    end
    if (apb_go) begin
      st_next.apb_rd = 1'b0;
      st_next.pready = 1'b1;
      st_next.pslverr = !addr_ok;
      st_next.prdata = pwrite ? 32'h0 : rd_mux;
    end
    if (wr_go) begin
      case (paddr)
        `CBUV_OFS_CTRL: begin
          // any control write aborts or relaunches
          st_next.mode = pwdata[2:0];
          st_next.meas_en = pwdata[`CBUV_CTRL_MEAS];
          st_next.finit = pwdata[`CBUV_CTRL_INIT];
          st_next.hold = pwdata[`CBUV_CTRL_HOLD];
          st_next.flags = hit_vec;
          st_next.cal_fault = 1'b0;
          st_next.cyc = 6'h00;
          st_next.mcnt = 5'h00;
          st_next.active = pwdata[2:0] != `CBUV_MODE_OFF;
          st_next.state = (pwdata[2:0] != `CBUV_MODE_OFF) ? CBUV_RUN : CBUV_IDLE;
        end
        `CBUV_OFS_THR: begin
          st_next.thr_min = pwdata[`CBUV_THR_MIN];
          st_next.thr = pwdata[`CBUV_THR_MIN] ? mem_res : pwdata[13:0];
        end
        `CBUV_OFS_SWEN: begin
          st_next.swen = pwdata[13:0];
        end
        `CBUV_OFS_DLY: begin
          st_next.cal_int = pwdata[2:0];
          st_next.apply_cal = pwdata[`CBUV_DLY_APPLY];
          st_next.fc = pwdata[`CBUV_DLY_FC];
        end
        `CBUV_OFS_STAT: begin
          if (pwdata[`CBUV_STAT_REJ]) begin
            st_next.rej = 1'b0;
          end
        end
        default: begin
          st_next.rej = st_reg.rej;
        end
      endcase
    end

    // scan parameters frozen while balancing; set beats the clear
    if (scan_wr) begin
      if (st_reg.active) begin
        st_next.rej = 1'b1;
      end else if (paddr == `CBUV_OFS_SCAN) begin
        st_next.scan = pwdata[15:0];
      end else begin
        st_next.meas_on = pwdata[13:0];
        st_next.pol = pwdata[`CBUV_CFG_POL];
      end
    end

    // switches open during acquisitions, faults and once all are done
    if (st_reg.state == CBUV_RUN && !timer_expired && !all_done) begin
      st_next.sw = st_reg.swen & ~st_reg.flags;
    end else begin
      st_next.sw = 14'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign prdata                  = st_reg.prdata;
  assign pready                  = st_reg.pready;
  assign pslverr                 = st_reg.pslverr;
  assign switch_on               = st_reg.sw;
  assign adc_start               = st_reg.adc_start;
  assign adc_cal                 = st_reg.adc_cal;
  assign adc_oversample          = st_reg.adc_ovs;
  assign adc_pyramid             = st_reg.adc_pyr;
  assign adc_scan_cfg            = st_reg.adc_scan;
  assign balance_active          = st_reg.active;
  assign balance_cal_fault_alert = st_reg.cal_fault;
  assign write_rejected_alert    = st_reg.rej;
  assign cell_uv_done_flags      = st_reg.flags;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_unsup_flag: assert property (
    st_reg.state == CBUV_RUN && chk_ok && !ctrl_wr
    |=> (cell_uv_done_flags & $past(unsup)) == $past(unsup))
    else $error("unsupported cell not flagged");

  a_uv_hit_flag: assert property (
    hit && !ctrl_wr |=> (cell_uv_done_flags & $past(hit_vec)) == $past(hit_vec))
    else $error("uv crossing not flagged");

  a_flag_gates_sw: assert property (
    cell_uv_done_flags != 14'h0000 |=> (switch_on & $past(cell_uv_done_flags)) == 14'h0000)
    else $error("flagged cell still switching");

  a_flag_clear: assert property (
    ctrl_wr && hit_vec == 14'h0000 |=> cell_uv_done_flags == 14'h0000)
    else $error("flags not cleared on control write");

  a_all_open: assert property (
    all_done |=> switch_on == 14'h0000)
    else $error("switches closed after all cells done");

  a_thr_load: assert property (
    wr_go && paddr == `CBUV_OFS_THR && pwdata[`CBUV_THR_MIN]
    |=> st_reg.thr == $past(mem_res) && st_reg.thr_min)
    else $error("threshold not loaded from lowest cell");

  a_no_meas: assert property (
    !meas_ok |=> !adc_start)
    else $error("acquisition with measurements disabled");

  a_forced_scan: assert property (
    adc_start |-> adc_oversample == `CBUV_OVS_16X && adc_pyramid)
    else $error("acquisition without forced scan settings");

  a_scan_reject: assert property (
    balance_active && scan_wr
    |=> write_rejected_alert && st_reg.scan == $past(st_reg.scan))
    else $error("scan write accepted while active");

  a_settle_check: assert property (
    hit |-> !st_reg.finit || st_reg.mcnt >= `CBUV_SETTLE)
    else $error("threshold checked before settling");

  a_first_cal: assert property (
    adc_start && cal_ok && st_reg.cyc == 6'h00 |-> adc_cal)
    else $error("scheduled calibration not issued");

  a_cal_halt: assert property (
    acq_done && st_reg.apply_cal && calibration_range_alert && !ctrl_wr && !timer_expired
    |=> balance_cal_fault_alert ##1 switch_on == 14'h0000)
    else $error("calibration fault did not halt");

  a_halt_quiet: assert property (
    st_reg.state == CBUV_HALT |=> !adc_start && switch_on == 14'h0000)
    else $error("activity after calibration fault");

  c_launch_auto: cover property (ctrl_wr && pwdata[2]);
  c_cal_op: cover property (adc_start && adc_cal);
  c_uv_hit: cover property (hit);
  c_halt: cover property (st_reg.state == CBUV_HALT);
endmodule // cbuv_seq

// File: cbuv_seq_tb_top.sv
// Purpose: self-checking bench for the balance uv sequencer
// Assumes: bench drives apb, adc and timer ports directly
// Notes: one task per scenario, all inputs change at rising edges
`timescale 1ns/10ps
`include "cbuv_defs.svh"
module cbuv_seq_tb_top import cbuv_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, pair_done, timer_expired, adc_done;
  logic        adc_result_valid, calibration_range_alert, st, cal, err;
  logic [3:0]  adc_result_cell, lowest_cell_index;
  logic [13:0] adc_result_data, switch_on, cell_uv_done_flags;
  logic        adc_start, adc_cal, adc_pyramid, balance_active;
  logic        balance_cal_fault_alert, write_rejected_alert;
  logic [2:0]  adc_oversample;
  logic [15:0] adc_scan_cfg;
  int          n_mismatch, tests_run, cycles;
  int          n_tab[8] = '{0, 2, 4, 8, 12, 16, 24, 32};

  cbuv_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pair_done(pair_done), .timer_expired(timer_expired),
    .adc_done(adc_done), .adc_result_valid(adc_result_valid),
    .adc_result_cell(adc_result_cell), .adc_result_data(adc_result_data),
    .calibration_range_alert(calibration_range_alert),
    .lowest_cell_index(lowest_cell_index), .switch_on(switch_on), .adc_start(adc_start),
    .adc_cal(adc_cal), .adc_oversample(adc_oversample), .adc_pyramid(adc_pyramid),
    .adc_scan_cfg(adc_scan_cfg), .balance_active(balance_active),
    .balance_cal_fault_alert(balance_cal_fault_alert),
    .write_rejected_alert(write_rejected_alert), .cell_uv_done_flags(cell_uv_done_flags));

  // 100 ns period
  always #50 pclk = ~pclk;

  // hang guard, well under 2000 cycles are expected
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask

  // pulse pair_done, then look for the start pulse for a few cycles
  task automatic pair();
    int i;
    @(posedge pclk);
    pair_done <= 1'b1;
    @(posedge pclk);
    pair_done <= 1'b0;
    st = 1'b0;
    cal = 1'b0;
    for (i = 0; i < 6 && st !== 1'b1; i++) begin
      @(posedge pclk);
      if (adc_start === 1'b1) begin
        st = 1'b1;
        cal = adc_cal;
      end
    end
  endtask

  task automatic res(input logic [3:0] c, input logic [13:0] d);
    @(posedge pclk);
    adc_result_valid <= 1'b1;
    adc_result_cell <= c;
    adc_result_data <= d;
    @(posedge pclk);
    adc_result_valid <= 1'b0;
  endtask

  task automatic op_done();
    @(posedge pclk);
    adc_done <= 1'b1;
    @(posedge pclk);
    adc_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_regs();
    rd("ctrl reset", `CBUV_OFS_CTRL, 32'h0);
    rd("thr reset", `CBUV_OFS_THR, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rdat, 32'h0);
    wr(`CBUV_OFS_THR, 32'hffff_7fff);
    rd("thr full", `CBUV_OFS_THR, 32'h0000_3fff);
    wr(`CBUV_OFS_SCAN, 32'h0000_abcd);
    rd("scan idle", `CBUV_OFS_SCAN, 32'h0000_abcd);
  endtask

  // cell 0 crosses, cell 1 stays above, cell 2 has no measurement
  task automatic t_check();
    wr(`CBUV_OFS_SWEN, 32'h0007);
    wr(`CBUV_OFS_CELLCFG, 32'h0000_0003);
    wr(`CBUV_OFS_DLY, 32'h0000_0700);
    wr(`CBUV_OFS_THR, 32'h0000_0100);
    wr(`CBUV_OFS_CTRL, 32'h0000_0034);
    chk("active", balance_active, 1'b1);
    pair();
    chk("start", st, 1'b1);
    chk("no cal", cal, 1'b0);
    chk("ovs", adc_oversample, `CBUV_OVS_16X);
    chk("pyramid", adc_pyramid, `CBUV_SCAN_PYRAMID);
    chk("scan copy", adc_scan_cfg, 16'habcd);
    res(4'h0, 14'h0000);
    res(4'h1, 14'h3fff);
    op_done();
    chk("flags", cell_uv_done_flags, 14'h0005);
    chk("switch", switch_on, 14'h0002);
    rd("uv status", `CBUV_OFS_UVST, 32'h0005);
    wr(`CBUV_OFS_SCAN, 32'h0000_1234);
    chk("reject", write_rejected_alert, 1'b1);
    rd("scan kept", `CBUV_OFS_SCAN, 32'h0000_abcd);
    // cell 1 took 0x3fff once at weight 1/8 from an empty accumulator
    lowest_cell_index <= 4'h1;
    wr(`CBUV_OFS_THR, 32'h0000_9234);
    rd("thr lowest", `CBUV_OFS_THR, 32'h0000_87ff);
    wr(`CBUV_OFS_CTRL, 32'h0);
    chk("flags clr", cell_uv_done_flags, 14'h0);
    chk("idle", balance_active, 1'b0);
  endtask

  // measurements skipped, then the expiry timer ends the run
  task automatic t_skip();
    wr(`CBUV_OFS_DLY, 32'h0000_0701);
    wr(`CBUV_OFS_CTRL, 32'h0000_0004);
    pair();
    chk("skip start", st, 1'b0);
    chk("timer only", switch_on, 14'h0007);
    wr(`CBUV_OFS_CTRL, 32'h0000_0031);
    pair();
    chk("manual start", st, 1'b0);
    timer_expired <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("expired", balance_active, 1'b0);
    timer_expired <= 1'b0;
  endtask

  // first and every nth operation calibrates, for interval codes 1 to 7
  task automatic t_cal();
    int c, k;
    for (c = 1; c < 8; c++) begin
      wr(`CBUV_OFS_DLY, 32'h0700 | c);
      wr(`CBUV_OFS_CTRL, 32'h0000_0024);
      for (k = 0; k <= n_tab[c]; k++) begin
        pair();
        chk("cal start", st, 1'b1);
        chk("cal pattern", cal, (k % n_tab[c]) == 0);
        op_done();
      end
    end
  endtask

  task automatic t_fault();
    wr(`CBUV_OFS_DLY, 32'h0000_0710);
    wr(`CBUV_OFS_CTRL, 32'h0000_0024);
    pair();
    calibration_range_alert <= 1'b1;
    op_done();
    chk("cal fault", balance_cal_fault_alert, 1'b1);
    chk("halted", switch_on, 14'h0);
    pair();
    chk("no start", st, 1'b0);
    calibration_range_alert <= 1'b0;
    wr(`CBUV_OFS_CTRL, 32'h0000_0024);
    chk("fault clr", balance_cal_fault_alert, 1'b0);
  endtask

  // init mode: checks wait for the 17th measurement; discharge never checks
  task automatic t_init();
    int k;
    wr(`CBUV_OFS_THR, 32'h0000_0100);
    wr(`CBUV_OFS_CTRL, 32'h0000_0074);
    for (k = 1; k <= 17; k++) begin
      pair();
      res(4'h0, 14'h0010);
      res(4'h1, 14'h0010);
      op_done();
      chk("settle", cell_uv_done_flags, (k == 17) ? 14'h0007 : 14'h0004);
      chk("all open", switch_on, (k == 17) ? 14'h0000 : 14'h0003);
    end
    wr(`CBUV_OFS_CTRL, 32'h0000_0032);
    pair();
    chk("dis start", st, 1'b1);
    res(4'h0, 14'h0010);
    op_done();
    chk("dis no check", cell_uv_done_flags, 14'h0000);
  endtask

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, pair_done, timer_expired, adc_done} = '0;
    {adc_result_valid, calibration_range_alert} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    adc_result_cell = 4'h0;
    adc_result_data = 14'h0;
    lowest_cell_index = 4'h1;
    n_mismatch = 0;
    tests_run = 0;
    cycles = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_check();
    t_skip();
    t_cal();
    t_fault();
    t_init();
    wrap_up();
  end
endmodule // cbuv_seq_tb_top
